/* File: rtl/mce_consts.svh */
// Constants of the instruction execute block: encodings, reset values, field positions.
// Assumes 14-bit instruction words and an 8-bit data path.
`ifndef MCE_CONSTS_SVH
`define MCE_CONSTS_SVH

`define MCE_PC_W          13
`define MCE_PC_RST        13'h0000
`define MCE_ACC_RST       8'h00
`define MCE_FILE_RST      8'h00
`define MCE_C_RST         1'b0
`define MCE_DC_RST        1'b0
`define MCE_Z_RST         1'b0
`define MCE_TO_RST        1'b1
`define MCE_PD_RST        1'b1
`define MCE_GIE_RST       1'b0
`define MCE_GIE_BIT       7
`define MCE_PAGE_HI       4
`define MCE_PAGE_LO       3
`define MCE_GRP_BYTE      2'h0
`define MCE_GRP_BIT       2'h1
`define MCE_GRP_JMP       2'h2
`define MCE_GRP_LIT       2'h3
`define MCE_BY_MISC       4'h0
`define MCE_BY_CLR        4'h1
`define MCE_BY_DEC        4'h3
`define MCE_BY_IOR        4'h4
`define MCE_BY_AND        4'h5
`define MCE_BY_ADD        4'h7
`define MCE_BY_MOV        4'h8
`define MCE_BY_COM        4'h9
`define MCE_BY_INC        4'hA
`define MCE_BY_DECSZ      4'hB
`define MCE_BY_INCSZ      4'hF
`define MCE_MISC_WDT      7'h64
`define MCE_MISC_RETI     7'h09
`define MCE_MISC_RET      7'h08
`define MCE_LIT_IOR       4'h8
`define MCE_LIT_AND       4'h9

`endif

/* File: rtl/mce_pkg.sv */
// Types of the instruction execute block: operation codes, decoded word and status flags.
// Assumes the constants header is compiled alongside.
package mce_pkg;

  typedef enum logic [4:0] {
    MCE_NOP, MCE_ADD_LIT, MCE_ADD_FILE, MCE_BIT_CLR, MCE_BIT_SET, MCE_SKIP_LOW, MCE_SKIP_HIGH,
    MCE_AND_LIT, MCE_AND_FILE, MCE_OR_LIT, MCE_OR_FILE, MCE_WDT_KICK, MCE_CALL, MCE_JUMP,
    MCE_INVERT, MCE_ZERO_FILE, MCE_ZERO_ACC, MCE_DEC, MCE_INC, MCE_DEC_SKIP, MCE_INC_SKIP,
    MCE_COPY, MCE_STORE_ACC, MCE_LOAD_LIT, MCE_IRQ_RET, MCE_RET_LIT, MCE_RET
  } mce_op_t;

  typedef struct packed {
    mce_op_t     op;
    logic        to_file;
    logic [6:0]  faddr;
    logic [2:0]  bsel;
    logic [10:0] k;
  } mce_dec_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic watchdog_expiry_flag;
    logic sleep_entry_flag;
  } mce_status_t;

endpackage

/* File: rtl/mce_alu.sv */
// Combinational data path: result and arithmetic flags for one operation.
// Assumes the caller decides which flags and destinations are actually updated.
`timescale 1ns/100ps
`default_nettype none

module mce_alu (
  // Operation.
  input  wire mce_pkg::mce_op_t op,
  // Operands.
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       fval,
  input  wire logic [7:0]       lit,
  input  wire logic [2:0]       bsel,
  // Results.
  output logic      [7:0]       res,
  output logic                  carry,
  output logic                  nib_carry,
  output logic                  zero
);

  logic [7:0] opnd;
  logic [8:0] sum9;
  logic [4:0] nib5;

  assign opnd = (op == mce_pkg::MCE_ADD_LIT) ? lit : fval;
  assign sum9 = {1'b0, acc} + {1'b0, opnd};
  assign nib5 = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};

  always_comb begin
    case (op)
      mce_pkg::MCE_ADD_LIT, mce_pkg::MCE_ADD_FILE: res = sum9[7:0];
      mce_pkg::MCE_AND_LIT:                        res = acc & lit;
      mce_pkg::MCE_OR_LIT:                         res = acc | lit;
      mce_pkg::MCE_AND_FILE:                       res = acc & fval;
      mce_pkg::MCE_OR_FILE:                        res = acc | fval;
      mce_pkg::MCE_BIT_CLR:                        res = fval & ~(8'h01 << bsel);
      mce_pkg::MCE_BIT_SET:                        res = fval | (8'h01 << bsel);
      mce_pkg::MCE_INVERT:                         res = ~fval;
      mce_pkg::MCE_DEC, mce_pkg::MCE_DEC_SKIP:     res = fval - 8'h01;
      mce_pkg::MCE_INC, mce_pkg::MCE_INC_SKIP:     res = fval + 8'h01;
      mce_pkg::MCE_COPY:                           res = fval;
      mce_pkg::MCE_STORE_ACC:                      res = acc;
      mce_pkg::MCE_LOAD_LIT, mce_pkg::MCE_RET_LIT: res = lit;
      default:                                     res = 8'h00;
    endcase
  end

  assign carry     = sum9[8];
  assign nib_carry = nib5[4];
  assign zero      = (res == 8'h00);

endmodule

`default_nettype wire

/* File: rtl/mce_core.sv */
// Instruction execute core: program counter, accumulator, file registers, stack and status flags.
// Assumes instr holds the word at pc_ff whenever instr_valid is high; one instruction cycle per clk.
`timescale 1ns/100ps
`default_nettype none
`include "mce_consts.svh"

module mce_core #(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS  = 128
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Instruction stream.
  input  wire logic                  instr_valid,
  input  wire logic [13:0]           instr,
  // Loose control inputs.
  input  wire logic [4:0]            program_page_latch,
  input  wire logic                  global_irq_clear,
  input  wire logic [6:0]            file_rd_addr,
  // State outputs.
  output logic [`MCE_PC_W-1:0]       pc_ff,
  output logic [7:0]                 acc_ff,
  output mce_pkg::mce_status_t       status_ff,
  output logic [7:0]                 interrupt_control_reg_ff,
  output logic                       watchdog_clear_ff,
  output logic                       nop_slot_ff,
  output logic [7:0]                 file_rd_data_ff
);

  localparam int SPW = $clog2(STACK_DEPTH);

  function automatic mce_pkg::mce_dec_t decode(input logic [13:0] w);
    mce_pkg::mce_dec_t r;
    r.op      = mce_pkg::MCE_NOP;
    r.to_file = w[7];
    r.faddr   = w[6:0];
    r.bsel    = w[9:7];
    r.k       = w[10:0];
    case (w[13:12])
      `MCE_GRP_BYTE: begin
        case (w[11:8])
          `MCE_BY_MISC: begin
            if (w[7]) begin
              r.op = mce_pkg::MCE_STORE_ACC;
            end else if (w[6:0] == `MCE_MISC_WDT) begin
              r.op = mce_pkg::MCE_WDT_KICK;
            end else if (w[6:0] == `MCE_MISC_RETI) begin
              r.op = mce_pkg::MCE_IRQ_RET;
            end else if (w[6:0] == `MCE_MISC_RET) begin
              r.op = mce_pkg::MCE_RET;
            end
          end
          `MCE_BY_CLR:   r.op = w[7] ? mce_pkg::MCE_ZERO_FILE : mce_pkg::MCE_ZERO_ACC;
          `MCE_BY_DEC:   r.op = mce_pkg::MCE_DEC;
          `MCE_BY_IOR:   r.op = mce_pkg::MCE_OR_FILE;
          `MCE_BY_AND:   r.op = mce_pkg::MCE_AND_FILE;
          `MCE_BY_ADD:   r.op = mce_pkg::MCE_ADD_FILE;
          `MCE_BY_MOV:   r.op = mce_pkg::MCE_COPY;
          `MCE_BY_COM:   r.op = mce_pkg::MCE_INVERT;
          `MCE_BY_INC:   r.op = mce_pkg::MCE_INC;
          `MCE_BY_DECSZ: r.op = mce_pkg::MCE_DEC_SKIP;
          `MCE_BY_INCSZ: r.op = mce_pkg::MCE_INC_SKIP;
          default:       r.op = mce_pkg::MCE_NOP;
        endcase
      end
      `MCE_GRP_BIT: begin
        case (w[11:10])
          2'h0:    r.op = mce_pkg::MCE_BIT_CLR;
          2'h1:    r.op = mce_pkg::MCE_BIT_SET;
          2'h2:    r.op = mce_pkg::MCE_SKIP_LOW;
          default: r.op = mce_pkg::MCE_SKIP_HIGH;
        endcase
      end
      `MCE_GRP_JMP: r.op = w[11] ? mce_pkg::MCE_JUMP : mce_pkg::MCE_CALL;
      default: begin
        if (w[11:9] == 3'h7) begin
          r.op = mce_pkg::MCE_ADD_LIT;
        end else if (w[11:8] == `MCE_LIT_AND) begin
          r.op = mce_pkg::MCE_AND_LIT;
        end else if (w[11:8] == `MCE_LIT_IOR) begin
          r.op = mce_pkg::MCE_OR_LIT;
        end else if (w[11:10] == 2'h0) begin
          r.op = mce_pkg::MCE_LOAD_LIT;
        end else if (w[11:10] == 2'h1) begin
          r.op = mce_pkg::MCE_RET_LIT;
        end
      end
    endcase
    return r;
  endfunction

  mce_pkg::mce_dec_t     dec;
  logic [7:0]            file_mem [FILE_WORDS];
  logic [`MCE_PC_W-1:0]  stack_ff [STACK_DEPTH];
  logic [SPW-1:0]        sp_ff;
  logic                  bubble_ff;
  logic                  exec;
  logic [7:0]            fval;
  logic [7:0]            res;
  logic                  alu_c;
  logic                  alu_dc;
  logic                  alu_z;
  logic                  skip;
  logic                  push;
  logic                  pop;
  logic                  wr_file;
  logic                  wr_acc;
  logic                  upd_cdc;
  logic                  upd_z;
  logic [`MCE_PC_W-1:0]  pc_inc;
  logic [`MCE_PC_W-1:0]  target;
  logic [SPW-1:0]        sp_dec;

  assign dec    = decode(instr);
  assign exec   = instr_valid & ~bubble_ff;
  assign fval   = file_mem[dec.faddr];
  assign pc_inc = pc_ff + 13'h0001;
  assign target = {program_page_latch[`MCE_PAGE_HI:`MCE_PAGE_LO], dec.k};
  assign sp_dec = sp_ff - 1'b1;

  mce_alu u_alu (
    .op        (dec.op),
    .acc       (acc_ff),
    .fval      (fval),
    .lit       (dec.k[7:0]),
    .bsel      (dec.bsel),
    .res       (res),
    .carry     (alu_c),
    .nib_carry (alu_dc),
    .zero      (alu_z)
  );

  always_comb begin
    skip    = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    wr_file = 1'b0;
    wr_acc  = 1'b0;
    upd_cdc = 1'b0;
    upd_z   = 1'b0;
    case (dec.op)
      mce_pkg::MCE_ADD_LIT: begin
        wr_acc  = 1'b1;
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      mce_pkg::MCE_ADD_FILE: begin
        wr_file = dec.to_file;
        wr_acc  = ~dec.to_file;
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      mce_pkg::MCE_BIT_CLR, mce_pkg::MCE_BIT_SET: wr_file = 1'b1;
      mce_pkg::MCE_SKIP_LOW:  skip = ~fval[dec.bsel];
      mce_pkg::MCE_SKIP_HIGH: skip = fval[dec.bsel];
      mce_pkg::MCE_AND_LIT, mce_pkg::MCE_OR_LIT, mce_pkg::MCE_ZERO_ACC: begin
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      mce_pkg::MCE_AND_FILE, mce_pkg::MCE_OR_FILE, mce_pkg::MCE_INVERT, mce_pkg::MCE_DEC,
      mce_pkg::MCE_INC, mce_pkg::MCE_COPY: begin
        wr_file = dec.to_file;
        wr_acc  = ~dec.to_file;
        upd_z   = 1'b1;
      end
      mce_pkg::MCE_ZERO_FILE: begin
        wr_file = 1'b1;
        upd_z   = 1'b1;
      end
      mce_pkg::MCE_DEC_SKIP, mce_pkg::MCE_INC_SKIP: begin
        wr_file = dec.to_file;
        wr_acc  = ~dec.to_file;
        skip    = alu_z;
      end
      mce_pkg::MCE_STORE_ACC: wr_file = 1'b1;
      mce_pkg::MCE_LOAD_LIT:  wr_acc = 1'b1;
      mce_pkg::MCE_CALL:      push = 1'b1;
      mce_pkg::MCE_IRQ_RET, mce_pkg::MCE_RET: pop = 1'b1;
      mce_pkg::MCE_RET_LIT: begin
        pop    = 1'b1;
        wr_acc = 1'b1;
      end
      default: skip = 1'b0;
    endcase
  end

  // Program counter and the discarded slot after a skip or a change of flow.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff     <= `MCE_PC_RST;
      bubble_ff <= 1'b0;
    end else if (bubble_ff) begin
      bubble_ff <= 1'b0;
    end else if (exec) begin
      case (dec.op)
        mce_pkg::MCE_CALL, mce_pkg::MCE_JUMP: begin
          pc_ff     <= target;
          bubble_ff <= 1'b1;
        end
        mce_pkg::MCE_IRQ_RET, mce_pkg::MCE_RET, mce_pkg::MCE_RET_LIT: begin
          pc_ff     <= stack_ff[sp_dec];
          bubble_ff <= 1'b1;
        end
        default: begin
          pc_ff     <= skip ? pc_ff + 13'h0002 : pc_inc;
          bubble_ff <= skip;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nop_slot_ff <= 1'b0;
    end else begin
      nop_slot_ff <= bubble_ff;
    end
  end

  // Hardware stack; wraps silently when more than STACK_DEPTH levels are used.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_ff <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_ff[i] <= `MCE_PC_RST;
      end
    end else if (exec && push) begin
      stack_ff[sp_ff] <= pc_inc;
      sp_ff           <= sp_ff + 1'b1;
    end else if (exec && pop) begin
      sp_ff <= sp_dec;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= `MCE_ACC_RST;
    end else if (exec && wr_acc) begin
      acc_ff <= res;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < FILE_WORDS; i++) begin
        file_mem[i] <= `MCE_FILE_RST;
      end
    end else if (exec && wr_file) begin
      file_mem[dec.faddr] <= res;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      file_rd_data_ff <= `MCE_FILE_RST;
    end else begin
      file_rd_data_ff <= file_mem[file_rd_addr];
    end
  end

  // Status flags; only the flags an operation names are written.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= '{`MCE_C_RST, `MCE_DC_RST, `MCE_Z_RST, `MCE_TO_RST, `MCE_PD_RST};
    end else if (exec) begin
      if (upd_cdc) begin
        status_ff.carry             <= alu_c;
        status_ff.nibble_carry_flag <= alu_dc;
      end
      if (upd_z) begin
        status_ff.zero <= alu_z;
      end
      if (dec.op == mce_pkg::MCE_WDT_KICK) begin
        status_ff.watchdog_expiry_flag <= 1'b1;
        status_ff.sleep_entry_flag     <= 1'b1;
      end
    end
  end

  // Watchdog counter and prescaler clear pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_clear_ff <= 1'b0;
    end else begin
      watchdog_clear_ff <= exec && (dec.op == mce_pkg::MCE_WDT_KICK);
    end
  end

  // Global interrupt enable; a set in the same cycle as a clear wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_control_reg_ff <= 8'h00;
    end else if (exec && dec.op == mce_pkg::MCE_IRQ_RET) begin
      interrupt_control_reg_ff[`MCE_GIE_BIT] <= 1'b1;
    end else if (global_irq_clear) begin
      interrupt_control_reg_ff[`MCE_GIE_BIT] <= 1'b0;
    end
  end

  logic [7:0] lit8;
  logic       is_add_lit;
  logic       is_bitop;
  logic       is_jmp;
  assign lit8       = instr[7:0];
  assign is_add_lit = exec && dec.op == mce_pkg::MCE_ADD_LIT;
  assign is_bitop   = exec && (dec.op == mce_pkg::MCE_BIT_CLR || dec.op == mce_pkg::MCE_BIT_SET);
  assign is_jmp     = exec && (dec.op == mce_pkg::MCE_CALL || dec.op == mce_pkg::MCE_JUMP);

  property p_add_lit;
    @(posedge clk) disable iff (!rstn) is_add_lit |=> acc_ff == 8'($past(acc_ff) + $past(lit8));
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

  property p_bit_flags;
    @(posedge clk) disable iff (!rstn) is_bitop |=> $stable(status_ff);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");

  property p_skip_low;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_SKIP_LOW && !fval[dec.bsel] |=> ##1 nop_slot_ff && $stable(acc_ff);
  endproperty
  a_skip_low: assert property (p_skip_low) else $error("skip if low gave no no-op slot");

  property p_skip_high_none;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_SKIP_HIGH && !fval[dec.bsel] |=> pc_ff == $past(pc_inc) ##1 !nop_slot_ff;
  endproperty
  a_skip_high_none: assert property (p_skip_high_none) else $error("skip if high skipped wrongly");

  property p_wdt;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_WDT_KICK |=> watchdog_clear_ff && status_ff.watchdog_expiry_flag
                                                  && status_ff.sleep_entry_flag;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog kick effects missing");

  property p_jump;
    @(posedge clk) disable iff (!rstn)
      is_jmp |=> pc_ff == {$past(program_page_latch[4:3]), $past(instr[10:0])} ##1 $stable(pc_ff);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or two-cycle timing wrong");

  property p_zero_acc;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_ZERO_ACC |=> acc_ff == 8'h00 && status_ff.zero;
  endproperty
  a_zero_acc: assert property (p_zero_acc) else $error("zero accumulator failed");

  property p_load_lit;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_LOAD_LIT |=> acc_ff == $past(lit8) && $stable(status_ff)
                                                  && pc_ff == $past(pc_inc);
  endproperty
  a_load_lit: assert property (p_load_lit) else $error("load literal wrong");

  property p_irq_ret;
    @(posedge clk) disable iff (!rstn)
      exec && dec.op == mce_pkg::MCE_IRQ_RET |=> interrupt_control_reg_ff[7] && bubble_ff;
  endproperty
  a_irq_ret: assert property (p_irq_ret) else $error("interrupt return did not enable");

  c_skip:   cover property (@(posedge clk) disable iff (!rstn) exec && skip);
  c_call:   cover property (@(posedge clk) disable iff (!rstn) exec && push);
  c_return: cover property (@(posedge clk) disable iff (!rstn) exec && pop ##2 exec);
  c_carry:  cover property (@(posedge clk) disable iff (!rstn) is_add_lit && alu_c && alu_dc);

endmodule

`default_nettype wire

/* File: tb/mce_tb.sv */
// Self-checking testbench for the instruction execute core: feeds instruction words, checks state outputs.
// Assumes mce_pkg and the rtl files are compiled first; no program memory is modelled.
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic                 clk;
  logic                 rstn;
  logic                 instr_valid;
  logic [13:0]          instr;
  logic [4:0]           program_page_latch;
  logic                 global_irq_clear;
  logic [6:0]           file_rd_addr;
  logic [12:0]          pc;
  logic [7:0]           acc;
  mce_pkg::mce_status_t status;
  logic [7:0]           icr;
  logic                 wdt_clr;
  logic                 nop_slot;
  logic [7:0]           rd_data;
  int                   n_errors;
  int                   total_checks;
  logic [12:0]          p;
  logic [26:0]          tbl [25];
  logic [14:0]          sk [8];

  mce_core #(.STACK_DEPTH(8), .FILE_WORDS(128)) DUT (
    .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .program_page_latch(program_page_latch), .global_irq_clear(global_irq_clear),
    .file_rd_addr(file_rd_addr), .pc_ff(pc), .acc_ff(acc), .status_ff(status),
    .interrupt_control_reg_ff(icr), .watchdog_clear_ff(wdt_clr), .nop_slot_ff(nop_slot),
    .file_rd_data_ff(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Presents a word at a rising edge; it executes at the following edge.
  task automatic run(input logic [13:0] w);
    @(posedge clk);
    instr       <= w;
    instr_valid <= 1'b1;
  endtask

  task automatic ex(input logic [13:0] w);
    run(w);
    run(14'h0000);
    @(negedge clk);
  endtask

  task automatic fchk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    file_rd_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk(rd_data, exp);
  endtask

  // Calls a subroutine whose first word is the return word given.
  task automatic call_ret(input logic [13:0] rw);
    p = pc + 13'h0002;
    run(14'h2555);
    run(14'h0000);
    run(rw);
    run(14'h0000);
    run(14'h0000);
    @(negedge clk);
    chk(pc, p);
    chk(nop_slot, 1'b1);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    conclude;
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    program_page_latch = 5'h1D;
    global_irq_clear = 1'b0;
    file_rd_addr = 7'h00;
    tbl = '{
      {14'h308F, 8'h8F, 5'h03},
      {14'h3E71, 8'h00, 5'h1F},
      {14'h303C, 8'h3C, 5'h1F},
      {14'h0090, 8'h3C, 5'h1F},
      {14'h0790, 8'h3C, 5'h0B},
      {14'h0710, 8'hB4, 5'h0B},
      {14'h390F, 8'h04, 5'h0B},
      {14'h39F0, 8'h00, 5'h0F},
      {14'h38A5, 8'hA5, 5'h0B},
      {14'h0510, 8'h20, 5'h0B},
      {14'h0490, 8'h20, 5'h0B},
      {14'h0910, 8'h87, 5'h0B},
      {14'h0990, 8'h87, 5'h0B},
      {14'h0191, 8'h87, 5'h0F},
      {14'h0A91, 8'h87, 5'h0B},
      {14'h0311, 8'h00, 5'h0F},
      {14'h0890, 8'h00, 5'h0B},
      {14'h0810, 8'h87, 5'h0B},
      {14'h0100, 8'h00, 5'h0F},
      {14'h0A10, 8'h88, 5'h0B},
      {14'h3E78, 8'h00, 5'h1F},
      {14'h0A11, 8'h02, 5'h1B},
      {14'h1791, 8'h02, 5'h1B},
      {14'h1011, 8'h02, 5'h1B},
      {14'h0064, 8'h02, 5'h1B}
    };
    sk = '{
      {14'h1B91, 1'b0}, {14'h1811, 1'b1},
      {14'h1F91, 1'b1}, {14'h1C11, 1'b0},
      {14'h0B92, 1'b0}, {14'h0F92, 1'b1},
      {14'h0F92, 1'b0}, {14'h0B92, 1'b1}
    };
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk(pc, 13'h0000);
    chk(acc, 8'h00);
    chk(status, 5'h03);
    chk(icr, 8'h00);
    for (int i = 0; i < 25; i++) begin
      ex(tbl[i][26:13]);
      chk(acc, tbl[i][12:5]);
      chk(status, tbl[i][4:0]);
    end
    run(14'h0064);
    run(14'h0000);
    @(negedge clk);
    chk(wdt_clr, 1'b1);
    @(negedge clk);
    chk(wdt_clr, 1'b0);
    fchk(7'h10, 8'h87);
    fchk(7'h11, 8'h80);
    for (int i = 0; i < 8; i++) begin
      ex(14'h3000);
      run(sk[i][14:1]);
      run(14'h305A);
      run(14'h0000);
      @(negedge clk);
      chk(acc, sk[i][0] ? 8'h00 : 8'h5A);
      chk(nop_slot, sk[i][0]);
      chk(status, 5'h1B);
    end
    fchk(7'h12, 8'h00);
    p = pc + 13'h0002;
    run(14'h2555);
    run(14'h0000);
    run(14'h0000);
    @(negedge clk);
    chk(pc, 13'h1D55);
    chk(nop_slot, 1'b1);
    run(14'h2AAA);
    program_page_latch <= 5'h12;
    run(14'h0000);
    run(14'h0000);
    @(negedge clk);
    chk(pc, 13'h12AA);
    run(14'h0008);
    run(14'h0000);
    run(14'h0000);
    @(negedge clk);
    chk(pc, p);
    call_ret(14'h34C3);
    chk(acc, 8'hC3);
    chk(status, 5'h1B);
    call_ret(14'h0009);
    chk(icr, 8'h80);
    @(posedge clk);
    global_irq_clear <= 1'b1;
    @(posedge clk);
    global_irq_clear <= 1'b0;
    @(negedge clk);
    chk(icr, 8'h00);
    conclude;
  end
endmodule

`default_nettype wire
